// [dv/pmb_properties.sv]
// Checker for the two-wire link.
// Assumes the interface signals arrive as plain inputs.
module pmb_properties #(
  parameter int unsigned TIMEOUT_CYC = 2000
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Slave drives
  input wire logic scl_dev_o,
  input wire logic scl_dev_oe,
  input wire logic sda_dev_o,
  input wire logic sda_dev_oe,
  // Host drives
  input wire logic scl_host_o,
  input wire logic scl_host_oe,
  input wire logic sda_host_o,
  input wire logic sda_host_oe,
  // Resolved lines
  input wire logic scl,
  input wire logic sda
);
  // ---------------------------------------------------------------
  // Line counters
  // ---------------------------------------------------------------
  logic [31:0] low_cnt, next_low_cnt;
  logic [7:0] high_cnt, next_high_cnt;
  always_comb begin
    next_low_cnt = scl ? 32'h0000_0000 : low_cnt + 32'h0000_0001;
    // Saturates so long idle stays counted as high
    next_high_cnt = (!scl || high_cnt == 8'hff) ? {8{scl}} : high_cnt + 8'h01;
  end
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      low_cnt <= 32'h0000_0000;
      high_cnt <= 8'h00;
    end else begin
      low_cnt <= next_low_cnt;
      high_cnt <= next_high_cnt;
    end
  end
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking clk_ev @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  dev_scl_low_a: assert property (scl_dev_oe |-> !scl_dev_o) else $error("slave scl high");
  dev_sda_low_a: assert property (sda_dev_oe |-> !sda_dev_o) else $error("slave sda high");
  host_low_only_a: assert property (!(scl_host_oe && scl_host_o) && !(sda_host_oe && sda_host_o))
    else $error("host drives high");
  stretch_in_low_a: assert property ($rose(scl_dev_oe) |-> !$past(scl)) else $error("stretch while high");
  stretch_on_host_a: assert property ($rose(scl_dev_oe) |-> scl_host_oe) else $error("stretch unheld");
  timeout_scl_free_a: assert property (low_cnt > TIMEOUT_CYC + 16 |-> !scl_dev_oe)
    else $error("scl kept after timeout");
  timeout_sda_free_a: assert property (low_cnt == TIMEOUT_CYC + 16 |-> !sda_dev_oe [*4])
    else $error("sda kept after timeout");
  sda_high_hold_a: assert property (high_cnt > 8'h08 |-> $stable(sda_dev_oe)) else $error("sda moved");
  stretch_c: cover property ($rose(scl_dev_oe));
  timeout_c: cover property (low_cnt == TIMEOUT_CYC + 16);
  start_c: cover property (scl && $fell(sda));
  ack_c: cover property ($rose(sda_dev_oe));
endmodule : pmb_properties

// [dv/pmbus_slave_transfer_faults_tb.sv]
// Bench: both ends on one link, a command table and a data model.
// Assumes the design files and checker are compiled first.
module pmbus_slave_transfer_faults_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned TO_CYC = 2000;
  logic core_clk, arst_n, cml_clr, hold_rx, cmd_known, rx_valid, rx_ready, tx_req, tx_valid;
  logic cmd_done, cmd_abort, cml, op_valid, op_ready, op_read_first, op_timeout;
  logic wr_valid, wr_ready, rd_valid, op_done, op_nack;
  logic [6:0] op_addr, own_addr;
  logic [7:0] cmd_wlen, cmd_rlen, rx_data, tx_data, op_nwr, op_nrd, wr_data, rd_data;
  logic [15:0] cmd_code;
  logic [31:0] lfsr, dsd;
  logic [7:0] wq[$], txq[$], rxq[$], rdq[$];
  int fail_count, check_count, n_done, n_abort;
  pmb_if link ();
  pmb_slave #(.TIMEOUT_CYC(TO_CYC)) u_pmb_slave (.core_clk, .arst_n, .bus(link), .addr_sel(3'h6), .own_addr,
    .cmd_code, .cmd_known, .cmd_wlen, .cmd_rlen, .rx_valid, .rx_ready, .rx_data, .tx_req, .tx_valid,
    .tx_data, .tx_flush(), .cmd_done, .cmd_abort, .cml, .cml_clr);
  pmb_host #(.QTR_CYC(12), .FORCE_CYC(3000)) u_pmb_host (.core_clk, .arst_n, .bus(link), .op_valid,
    .op_ready, .op_addr, .op_read_first, .op_nwr, .op_nrd, .op_timeout, .wr_valid, .wr_ready, .wr_data,
    .rd_valid, .rd_data, .op_done, .op_nack);
  pmb_properties #(.TIMEOUT_CYC(TO_CYC)) chk (.core_clk, .arst_n, .scl_dev_o(link.scl_dev_o),
    .scl_dev_oe(link.scl_dev_oe), .sda_dev_o(link.sda_dev_o), .sda_dev_oe(link.sda_dev_oe),
    .scl_host_o(link.scl_host_o), .scl_host_oe(link.scl_host_oe), .sda_host_o(link.sda_host_o),
    .sda_host_oe(link.sda_host_oe), .scl(link.scl), .sda(link.sda));
  // ---------------------------------------------------------------
  // Command table and random source
  // ---------------------------------------------------------------
  function automatic logic [16:0] tbl(input logic [15:0] c);
    case (c)
      16'h0001: return {1'b1, 8'h01, 8'h01};
      16'hfe10: return {1'b1, 8'h02, 8'h02};
      16'h0020: return {1'b1, 8'h00, 8'h02};
      16'h0030: return {1'b1, 8'h01, 8'h00};
      16'h0040: return {1'b1, 8'h00, 8'h00};
      default: return 17'h0_0000;
    endcase
  endfunction : tbl
  function automatic logic [31:0] step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : step
  assign {cmd_known, cmd_wlen, cmd_rlen} = tbl(cmd_code);
  initial begin
    core_clk = 0;
    forever #4 core_clk = ~core_clk;
  end
  // Random stalls on both data handshakes
  always @(posedge core_clk) begin
    if (tx_req && tx_valid) txq.push_back(tx_data);
    if (rx_valid && rx_ready) rxq.push_back(rx_data);
    if (rd_valid) rdq.push_back(rd_data);
    if (wr_valid && wr_ready) void'(wq.pop_front());
    n_done += int'(cmd_done);
    n_abort += int'(cmd_abort);
    lfsr = step(lfsr);
    #1;
    rx_ready = lfsr[0] && !hold_rx;
    tx_valid = lfsr[1];
    tx_data = lfsr[15:8];
    wr_valid = wq.size() != 0;
    wr_data = wr_valid ? wq[0] : 8'h00;
  end
  task automatic check(input string nm, input logic [15:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic print_verdict();
    if (fail_count == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict
  // ---------------------------------------------------------------
  // One transaction against the model
  // ---------------------------------------------------------------
  task automatic op(input logic [6:0] a, input logic rf, input logic [15:0] c, input int nw, nr,
    input logic hold, to);
    int cb, w;
    logic [16:0] t;
    logic ok, bad, full;
    logic [7:0] ew[$];
    cb = (c[15:8] != 8'h00) ? 2 : 1;
    t = tbl(c);
    ok = !to && (a == 7'h67 || a == 7'h00);
    bad = !rf && (!t[16] || nw > cb + t[15:8]);
    full = nw == cb + t[15:8];
    wq.delete();
    txq.delete();
    rxq.delete();
    rdq.delete();
    n_done = 0;
    n_abort = 0;
    if (!rf && !to) begin
      if (cb == 2) wq.push_back(c[15:8]);
      wq.push_back(c[7:0]);
      while (wq.size() < nw) begin
        dsd = step(dsd);
        wq.push_back(dsd[7:0]);
      end
      ew = wq;
    end
    hold_rx = hold;
    cml_clr = 1;
    @(posedge core_clk);
    #1 cml_clr = 0;
    check("cml_clr", cml, 0);
    {op_valid, op_addr, op_read_first, op_nwr, op_nrd, op_timeout} = {1'b1, a, rf, 8'(nw), 8'(nr), to};
    do @(posedge core_clk); while (op_ready !== 1'b1);
    #1 op_valid = 0;
    for (w = 0; w < 50000 && op_done !== 1'b1; w++) @(posedge core_clk);
    check("op_done", w < 50000, 1);
    check("op_nack", op_nack, !to && (!ok || bad || hold));
    repeat (8) @(posedge core_clk);
    #1;
    if (!hold) check("cml", cml, ok && (rf || bad || nr > t[7:0]));
    check("rd_count", 16'(rdq.size()), 16'(nr));
    foreach (rdq[k]) check("rd_data", rdq[k], (rf || k >= t[7:0]) ? 8'hff : txq[k]);
    if (ok && !rf && !bad && !hold) begin
      check("rx_count", 16'(rxq.size()), 16'(nw - cb));
      foreach (rxq[k]) check("rx_data", rxq[k], ew[cb + k]);
    end
    if (nr == 0 && !rf) begin
      check("cmd_done", 16'(n_done), ok && !bad && !hold && full);
      check("cmd_abort", 16'(n_abort), ok && (bad || hold || !full));
    end
  endtask : op
  initial begin
    {arst_n, cml_clr, hold_rx, op_valid, op_read_first, op_timeout} = '0;
    {op_addr, op_nwr, op_nrd} = '0;
    lfsr = 32'h0000_a22f;
    dsd = lfsr;
    repeat (6) @(posedge core_clk);
    #1 arst_n = 1;
    repeat (6) @(posedge core_clk);
    check("own_addr", own_addr, 7'h67);
    op(7'h67, 0, 16'h0001, 2, 0, 0, 0);
    op(7'h67, 0, 16'h0001, 1, 1, 0, 0);
    op(7'h67, 0, 16'hfe10, 4, 0, 0, 0);
    op(7'h67, 0, 16'hfe10, 2, 2, 0, 0);
    op(7'h00, 0, 16'h0001, 2, 0, 0, 0);
    op(7'h67, 0, 16'h0001, 3, 0, 0, 0);
    op(7'h67, 0, 16'h0020, 2, 0, 0, 0);
    op(7'h67, 0, 16'h0020, 1, 4, 0, 0);
    op(7'h67, 0, 16'h0030, 1, 2, 0, 0);
    op(7'h67, 0, 16'h0055, 1, 0, 0, 0);
    op(7'h67, 0, 16'hfe99, 2, 0, 0, 0);
    op(7'h67, 1, 16'h0000, 0, 2, 0, 0);
    op(7'h67, 0, 16'h0040, 1, 0, 0, 0);
    op(7'h67, 0, 16'h0001, 1, 0, 0, 0);
    op(7'h61, 0, 16'h0001, 2, 0, 0, 0);
    // Data byte never taken: slave must give up on its own
    op(7'h67, 0, 16'h0001, 2, 0, 1, 0);
    op(7'h67, 0, 16'h0001, 0, 0, 0, 1);
    print_verdict();
  end
  initial begin
    #600_000;
    fail_count++;
    print_verdict();
  end
endmodule : pmbus_slave_transfer_faults_tb

// [src/pin_sync.sv]
// Two-flop synchroniser for asynchronous pins.
// Assumes pins idle high; the first stage feeds only the second.
module pin_sync #(
  parameter int unsigned WIDTH = 2
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Pins
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] pin_s
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta <= '1;
      pin_s <= '1;
    end else begin
      meta <= pin;
      pin_s <= meta;
    end
  end
endmodule : pin_sync

// [src/pmb_host.sv]
// PMBus host end: divides core_clk into the bus clock, runs transactions.
// Assumes one request at a time; write bytes arrive on a stream.
module pmb_host #(
  parameter int unsigned QTR_CYC = pmb_pkg::QTR_CYC,
  parameter int unsigned FORCE_CYC = pmb_pkg::FORCE_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Two-wire link
  pmb_if.host bus,
  // Operation request
  input wire logic op_valid,
  output logic op_ready,
  input wire logic [6:0] op_addr,
  input wire logic op_read_first,
  input wire logic [7:0] op_nwr,
  input wire logic [7:0] op_nrd,
  input wire logic op_timeout,
  // Write bytes
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [7:0] wr_data,
  // Read bytes
  output logic rd_valid,
  output logic [7:0] rd_data,
  // Completion
  output logic op_done,
  output logic op_nack
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    M_IDLE = 5'b0_0001,
    M_START = 5'b0_0010,
    M_BIT = 5'b0_0100,
    M_STOP = 5'b0_1000,
    M_HOLD = 5'b1_0000
  } mst_t;

  typedef struct packed {
    mst_t st;
    logic [1:0] q;
    logic [31:0] cnt;
    logic [3:0] nbit;
    logic [7:0] sh;
    logic is_addr;
    logic is_rx;
    logic ph_rd;
    logic need_wr;
    logic lnack;
    logic [6:0] addr;
    logic [7:0] wleft;
    logic [7:0] rleft;
    logic scl_oe;
    logic sda_oe;
    logic rdv;
    logic [7:0] rdd;
    logic done;
    logic nack;
  } hst_t;

  hst_t r;
  hst_t n;
  logic [1:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic tick;

  pin_sync #(.WIDTH(2)) u_sync (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .pin({bus.scl, bus.sda}),
    .pin_s(pins_s)
  );
  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];
  assign tick = (r.cnt == 32'(QTR_CYC - 1)) && !r.need_wr;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [7:0] wl;
    logic [7:0] rl;
    wl = r.wleft;
    rl = r.rleft;
    n = r;
    n.rdv = 1'b0;
    n.done = 1'b0;
    n.cnt = tick ? 32'h0 : r.cnt + 32'h1;
    // Stretch: high quarter waits for the line
    if (r.q == 2'h1 && !scl_s) begin
      n.cnt = 32'h0;
    end
    if (tick) begin
      n.q = r.q + 2'h1;
    end

    unique case (r.st)
      M_IDLE: begin
        n.cnt = 32'h0;
        n.q = 2'h0;
        if (op_valid) begin
          n.addr = op_addr;
          n.wleft = op_nwr;
          n.rleft = op_nrd;
          n.ph_rd = op_read_first;
          n.nack = 1'b0;
          n.sda_oe = 1'b0;
          n.scl_oe = op_timeout;
          n.st = op_timeout ? M_HOLD : M_START;
        end
      end
      M_HOLD: begin
        n.cnt = r.cnt + 32'h1;
        if (r.cnt == 32'(FORCE_CYC - 1)) begin
          n.scl_oe = 1'b0;
          n.st = M_IDLE;
          n.done = 1'b1;
        end
      end
      M_START: begin
        if (tick) begin
          unique case (r.q)
            2'h0: n.scl_oe = 1'b0;
            2'h1: n.sda_oe = 1'b1;
            2'h2: n.scl_oe = 1'b1;
            2'h3: begin
              n.st = M_BIT;
              n.nbit = 4'h0;
              n.is_addr = 1'b1;
              n.is_rx = 1'b0;
              n.sh = {r.addr, r.ph_rd ? pmb_pkg::BIT_RD : pmb_pkg::BIT_WR};
              n.sda_oe = ~r.addr[6];
            end
          endcase
        end
      end
      M_STOP: begin
        if (tick) begin
          unique case (r.q)
            2'h0: n.scl_oe = 1'b0;
            2'h1: n.sda_oe = 1'b0;
            2'h2: begin
            end
            2'h3: begin
              n.st = M_IDLE;
              n.done = 1'b1;
            end
          endcase
        end
      end
      M_BIT: begin
        if (r.need_wr) begin
          n.cnt = 32'h0;
          if (wr_valid) begin
            n.need_wr = 1'b0;
            n.sh = wr_data;
            n.sda_oe = ~wr_data[7];
          end
        end else if (tick) begin
          unique case (r.q)
            2'h0: n.scl_oe = 1'b0;
            2'h1: begin
              if (r.nbit != 4'h8 && r.is_rx) begin
                n.sh = {r.sh[6:0], sda_s};
              end else if (r.nbit == 4'h8 && !r.is_rx) begin
                n.lnack = sda_s;
                n.nack = r.nack | sda_s;
              end
            end
            2'h2: n.scl_oe = 1'b1;
            2'h3: begin
              if (r.nbit != 4'h8) begin
                n.nbit = r.nbit + 4'h1;
                if (r.is_rx) begin
                  // Ack every read byte but the last
                  n.sda_oe = (r.nbit == 4'h7) && (r.rleft != 8'h01);
                end else begin
                  n.sh = {r.sh[6:0], 1'b0};
                  n.sda_oe = (r.nbit != 4'h7) && !r.sh[6];
                end
              end else begin
                n.sda_oe = 1'b0;
                n.nbit = 4'h0;
                if (r.is_rx) begin
                  n.rdv = 1'b1;
                  n.rdd = r.sh;
                  rl = r.rleft - 8'h01;
                end else if (!r.is_addr) begin
                  wl = r.wleft - 8'h01;
                end
                n.wleft = wl;
                n.rleft = rl;
                n.is_addr = 1'b0;
                if (r.is_addr && r.lnack) begin
                  n.st = M_STOP;
                  n.sda_oe = 1'b1;
                end else if (!r.ph_rd && wl != 8'h00) begin
                  n.is_rx = 1'b0;
                  n.need_wr = 1'b1;
                end else if (!r.ph_rd && rl != 8'h00) begin
                  n.st = M_START;
                  n.ph_rd = 1'b1;
                end else if (r.ph_rd && rl != 8'h00) begin
                  n.is_rx = 1'b1;
                end else begin
                  n.st = M_STOP;
                  n.sda_oe = 1'b1;
                end
              end
            end
          endcase
        end
      end
      default: begin
        n.st = M_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '0;
      r.st <= M_IDLE;
    end else begin
      r <= n;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign bus.scl_host_o = 1'b0;
  assign bus.sda_host_o = 1'b0;
  assign bus.scl_host_oe = r.scl_oe;
  assign bus.sda_host_oe = r.sda_oe;
  assign op_ready = (r.st == M_IDLE);
  assign wr_ready = (r.st == M_BIT) && r.need_wr;
  assign rd_valid = r.rdv;
  assign rd_data = r.rdd;
  assign op_done = r.done;
  assign op_nack = r.nack;
endmodule : pmb_host

// [src/pmb_if.sv]
// Two-wire open-drain bus joining the slave port and the host.
// Assumes a pull-up: a line is low only while an end drives it.
interface pmb_if;
  logic scl_dev_o, scl_dev_oe, sda_dev_o, sda_dev_oe;
  logic scl_host_o, scl_host_oe, sda_host_o, sda_host_oe;
  logic scl, sda;

  // ---------------------------------------------------------------
  // Wired-AND resolution
  // ---------------------------------------------------------------
  assign scl = (scl_dev_oe ? scl_dev_o : 1'b1) & (scl_host_oe ? scl_host_o : 1'b1);
  assign sda = (sda_dev_oe ? sda_dev_o : 1'b1) & (sda_host_oe ? sda_host_o : 1'b1);

  modport device (
    input scl, sda,
    output scl_dev_o, scl_dev_oe, sda_dev_o, sda_dev_oe
  );
  modport host (
    input scl, sda,
    output scl_host_o, scl_host_oe, sda_host_o, sda_host_oe
  );
endinterface : pmb_if

// [src/pmb_pkg.sv]
// Shared constants for the PMBus slave port and its host end.
// Assumes both ends run on a 125 MHz core clock with asynchronous reset.
package pmb_pkg;
  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned TIMEOUT_MS = 25;
  localparam int unsigned TIMEOUT_CYC = CLK_HZ / 1000 * TIMEOUT_MS;
  localparam int unsigned FORCE_MS = 35;
  localparam int unsigned FORCE_CYC = CLK_HZ / 1000 * FORCE_MS;
  localparam int unsigned BUS_KHZ = 100;
  // Quarter bit, rounded up so no phase runs short
  localparam int unsigned QTR_CYC = (CLK_HZ + 4000 * BUS_KHZ - 1) / (4000 * BUS_KHZ);
  localparam logic [2:0] STRAP_CYC = 3'h3;

  // ---------------------------------------------------------------
  // Codes on the wire
  // ---------------------------------------------------------------
  localparam logic [6:0] ADDR_BASE = 7'h60;
  localparam logic [6:0] ADDR_TOP = 7'h67;
  localparam logic [6:0] ADDR_GCALL = 7'h00;
  localparam logic [7:0] FILL_BYTE = 8'hFF;
  // Command bytes 0xFE and 0xFF open a two-byte code
  localparam logic [6:0] EXT_PREFIX = 7'h7F;
  localparam logic BIT_WR = 1'b0;
  localparam logic BIT_RD = 1'b1;
  localparam logic BIT_ACK = 1'b0;
  localparam logic BIT_NACK = 1'b1;

  function automatic logic [6:0] addr_of(input logic [2:0] sel);
    return (sel > 3'h5) ? ADDR_TOP : ADDR_BASE + {4'h0, sel};
  endfunction : addr_of

  function automatic logic is_ext(input logic [7:0] code);
    return code[7:1] == EXT_PREFIX;
  endfunction : is_ext
endpackage : pmb_pkg

// [src/pmb_slave.sv]
// PMBus slave port: byte framing, command decode, stretching, faults.
// Assumes a host on the bus and a command table looked up from cmd_code.
//
// Notes on behaviour
// - Bytes LSB first, bits MSB first
// - Write bit 0, read 1; ack 0
// - Host starts with write address, command
// - Two-byte codes 0xFE00 to 0xFFFF decoded
// - Clock only held low, never driven high
// - Stretch while data not taken or ready
// - Clock low 25 ms aborts and resets
// - Forced timeout holds clock 35 ms
// - No cumulative stretch limits, single pulse only
// - Own address and general call acknowledged
// - Same behaviour at 100 and 400 kHz
// - No packet error check byte
// - Partial byte before start/stop dropped silently
// - Early stop flushes transmit data, aborts a write
// - Excess written bytes refused, fault set
// - Excess reads return 0xFF, fault set
// - Read-first address acked, reads return 0xFF, fault
// - Unknown command refused, fault set
// - Reserved bits ignored on write, read zero
// - Data to read-only command refused, fault
// - Read of write-only command returns 0xFF
// - Send command takes effect at stop
// - Own address picked from strap at power-up
module pmb_slave #(
  parameter int unsigned TIMEOUT_CYC = pmb_pkg::TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Two-wire link
  pmb_if.device bus,
  // Address strap
  input wire logic [2:0] addr_sel,
  output logic [6:0] own_addr,
  // Command lookup
  output logic [15:0] cmd_code,
  input wire logic cmd_known,
  input wire logic [7:0] cmd_wlen,
  input wire logic [7:0] cmd_rlen,
  // Received data
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [7:0] rx_data,
  // Transmit data
  output logic tx_req,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_flush,
  // Transaction end
  output logic cmd_done,
  output logic cmd_abort,
  // Fault flag
  output logic cml,
  input wire logic cml_clr
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef enum logic [6:0] {
    ST_IDLE = 7'b000_0001,
    ST_RECV = 7'b000_0010,
    ST_HAND = 7'b000_0100,
    ST_ACK = 7'b000_1000,
    ST_LOAD = 7'b001_0000,
    ST_SEND = 7'b010_0000,
    ST_MACK = 7'b100_0000
  } st_t;

  typedef struct packed {
    st_t st;
    logic [7:0] sh;
    logic [3:0] nbit;
    logic is_addr;
    logic txn;
    logic first;
    logic rw;
    logic ext;
    logic bad;
    logic mnack;
    logic [7:0] nwr;
    logic [7:0] nrd;
    logic [15:0] cmd;
    logic [7:0] rxd;
    logic scl_oe;
    logic sda_oe;
    logic scl_q;
    logic sda_q;
    logic done;
    logic abort;
    logic flush;
    logic cml;
    logic [2:0] strap;
    logic [6:0] own;
    logic [31:0] tmr;
  } slv_t;

  slv_t r;
  slv_t n;
  logic [4:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic rise;
  logic fall;
  logic start_c;
  logic stop_c;
  logic [8:0] ncmd;
  logic [8:0] wend;
  logic is_cmd;
  logic cmd_end;
  logic in_range;
  logic fill;

  pin_sync #(.WIDTH(5)) u_sync (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .pin({addr_sel, bus.scl, bus.sda}),
    .pin_s(pins_s)
  );
  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  // ---------------------------------------------------------------
  // Bus events and command position
  // ---------------------------------------------------------------
  // Sampling far outruns either bus rate
  assign rise = scl_s & ~r.scl_q;
  assign fall = ~scl_s & r.scl_q;
  assign start_c = scl_s & r.scl_q & r.sda_q & ~sda_s;
  assign stop_c = scl_s & r.scl_q & ~r.sda_q & sda_s;

  assign ncmd = r.ext ? 9'h002 : 9'h001;
  assign wend = ncmd + {1'b0, cmd_wlen};
  assign is_cmd = {1'b0, r.nwr} < ncmd;
  assign cmd_end = {1'b0, r.nwr} == ncmd - 9'h001;
  assign in_range = {1'b0, r.nwr} < wend;
  assign fill = r.bad || (r.nrd >= cmd_rlen);

  assign rx_valid = (r.st == ST_HAND) && !r.is_addr && !r.bad && !is_cmd && in_range;
  assign tx_req = (r.st == ST_LOAD) && !fill;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic set_f;
    logic go_ack;
    logic ack_bit;
    logic go_send;
    logic [7:0] ld;
    set_f = 1'b0;
    go_ack = 1'b0;
    ack_bit = pmb_pkg::BIT_ACK;
    go_send = 1'b0;
    ld = pmb_pkg::FILL_BYTE;
    n = r;
    n.scl_q = scl_s;
    n.sda_q = sda_s;
    n.done = 1'b0;
    n.abort = 1'b0;
    n.flush = 1'b0;
    n.cml = r.cml & ~cml_clr;
    if (r.strap != pmb_pkg::STRAP_CYC) begin
      n.strap = r.strap + 3'h1;
      n.own = pmb_pkg::addr_of(pins_s[4:2]);
    end
    // Single low pulse only; no cumulative limit
    n.tmr = (scl_s || (r.st == ST_IDLE && !r.txn)) ? 32'h0 : r.tmr + 32'h1;

    unique case (r.st)
      ST_IDLE: begin
      end
      ST_RECV: begin
        if (rise) begin
          n.sh = {r.sh[6:0], sda_s};
          n.nbit = r.nbit + 4'h1;
        end else if (fall && r.nbit == 4'h8) begin
          n.st = ST_HAND;
          n.scl_oe = 1'b1;
          n.rxd = r.sh;
          if (!r.is_addr && r.nwr == 8'h00) begin
            n.cmd = {8'h00, r.sh};
            n.ext = pmb_pkg::is_ext(r.sh);
          end else if (!r.is_addr && r.nwr == 8'h01 && r.ext) begin
            n.cmd = {r.cmd[7:0], r.sh};
          end
        end
      end
      ST_HAND: begin
        if (r.is_addr) begin
          if (r.sh[7:1] == r.own || r.sh[7:1] == pmb_pkg::ADDR_GCALL) begin
            go_ack = 1'b1;
            n.txn = 1'b1;
            n.first = 1'b0;
            n.rw = r.sh[0];
            n.nrd = 8'h00;
            if (r.sh[0] == pmb_pkg::BIT_WR) begin
              n.nwr = 8'h00;
              n.ext = 1'b0;
            end else if (r.first) begin
              n.bad = 1'b1;
              set_f = 1'b1;
            end
          end else begin
            n.st = ST_IDLE;
            n.scl_oe = 1'b0;
          end
        end else begin
          // Checksum bytes are not recognised; they count as data
          if (r.bad) begin
            go_ack = 1'b1;
            ack_bit = pmb_pkg::BIT_NACK;
          end else if (is_cmd) begin
            go_ack = 1'b1;
            if (cmd_end && !cmd_known) begin
              ack_bit = pmb_pkg::BIT_NACK;
              n.bad = 1'b1;
              set_f = 1'b1;
            end
          end else if (!in_range) begin
            go_ack = 1'b1;
            ack_bit = pmb_pkg::BIT_NACK;
            n.bad = 1'b1;
            set_f = 1'b1;
          end else begin
            go_ack = rx_ready;
          end
          if (go_ack && r.nwr != 8'hFF) begin
            n.nwr = r.nwr + 8'h01;
          end
        end
      end
      ST_ACK: begin
        if (fall) begin
          n.sda_oe = 1'b0;
          n.is_addr = 1'b0;
          n.nbit = 4'h0;
          n.st = r.rw ? ST_LOAD : ST_RECV;
          n.scl_oe = r.rw;
        end
      end
      ST_LOAD: begin
        // Table zeroes reserved bits
        if (fill) begin
          go_send = 1'b1;
          set_f = 1'b1;
        end else if (tx_valid) begin
          go_send = 1'b1;
          ld = tx_data;
        end
      end
      ST_SEND: begin
        if (fall && r.nbit == 4'h7) begin
          n.sda_oe = 1'b0;
          n.st = ST_MACK;
        end else if (fall) begin
          n.nbit = r.nbit + 4'h1;
          n.sh = {r.sh[6:0], 1'b0};
          n.sda_oe = ~r.sh[6];
        end
      end
      ST_MACK: begin
        if (rise) begin
          n.mnack = sda_s;
        end else if (fall) begin
          n.st = r.mnack ? ST_IDLE : ST_LOAD;
          n.scl_oe = ~r.mnack;
        end
      end
      default: begin
        n.st = ST_IDLE;
      end
    endcase

    if (go_ack) begin
      n.st = ST_ACK;
      n.sda_oe = (ack_bit == pmb_pkg::BIT_ACK);
      n.scl_oe = 1'b0;
    end
    if (go_send) begin
      n.st = ST_SEND;
      n.sh = ld;
      n.sda_oe = ~ld[7];
      n.scl_oe = 1'b0;
      n.nbit = 4'h0;
      n.nrd = (r.nrd == 8'hFF) ? r.nrd : r.nrd + 8'h01;
    end

    if (stop_c || r.tmr == 32'(TIMEOUT_CYC - 1)) begin
      // Early stop is no fault; unread transmit bytes are dropped
      n.flush = r.txn;
      if (stop_c && r.txn && !r.rw && !r.bad && {1'b0, r.nwr} == wend) begin
        n.done = 1'b1;
      end else begin
        n.abort = r.txn && (!r.rw || !stop_c);
      end
      n.st = ST_IDLE;
      n.scl_oe = 1'b0;
      n.sda_oe = 1'b0;
      n.txn = 1'b0;
      n.first = 1'b1;
      n.bad = 1'b0;
      n.tmr = 32'h0;
    end else if (start_c) begin
      n.st = ST_RECV;
      n.nbit = 4'h0;
      n.is_addr = 1'b1;
      n.sda_oe = 1'b0;
      n.scl_oe = 1'b0;
    end

    if (set_f) begin
      n.cml = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '0;
      r.st <= ST_IDLE;
      r.first <= 1'b1;
      r.scl_q <= 1'b1;
      r.sda_q <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign bus.scl_dev_o = 1'b0;
  assign bus.sda_dev_o = 1'b0;
  assign bus.scl_dev_oe = r.scl_oe;
  assign bus.sda_dev_oe = r.sda_oe;
  assign own_addr = r.own;
  assign cmd_code = r.cmd;
  assign rx_data = r.rxd;
  assign tx_flush = r.flush;
  assign cmd_done = r.done;
  assign cmd_abort = r.abort;
  assign cml = r.cml;
endmodule : pmb_slave
